/* File: shared/rbm_pkg.sv */
// Constants, register map and field layout for the lane bonding and rate match block
package rbm_pkg;
    localparam int SEQ_MAX = 4;
    localparam int DEPTH = 32;
    localparam int PTR_W = 5;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_SKEW = 8'h08;
    localparam logic [7:0] ADDR_CNT = 8'h0C;
    localparam logic [7:0] ADDR_SEQ_BASE = 8'h40;
    // Sequence table: 4 tables (bond1, bond2, corr1, corr2) x SEQ_MAX symbols
    localparam int TBL_BOND1 = 0;
    localparam int TBL_BOND2 = 1;
    localparam int TBL_CORR1 = 2;
    localparam int TBL_CORR2 = 3;
    // CTRL fields
    localparam int CTRL_BOND_EN = 0;
    localparam int CTRL_BOND_TWO = 1;
    localparam int CTRL_CORR_EN = 2;
    localparam int CTRL_CORR_TWO = 3;
    localparam int CTRL_BLEN_LSB = 4;
    localparam int CTRL_CLEN_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Bits of CTRL that hold a field; the rest read back as zero
    localparam logic [31:0] CTRL_MASK = 32'h0000_077F;
    // Symbol entry fields
    localparam int SYM_CTRL_BIT = 8;
    localparam int SYM_INV_BIT = 9;
    localparam int SYM_ANY_BIT = 10;
    localparam logic [10:0] SYM_RESET = 11'h400;
    localparam logic [3:0] SKEW_RESET = 4'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [PTR_W-1:0] OCC_MID = 5'h10;
    localparam logic [PTR_W-1:0] OCC_SLACK = 5'h04;
endpackage : rbm_pkg

/* File: tb/rbm_remote_tx.sv */
// Remote transmitter model: filler, periodic correction pairs, one bonding mark every 256 cycles
`timescale 1ns/1ns
module rbm_remote_tx (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Behaviour
    input wire logic i_slow,
    input wire logic i_cc_ctrl,
    input wire logic i_bond,
    // Symbol stream
    output logic o_valid,
    output logic [7:0] o_data,
    output logic o_ctrl,
    output logic o_inv
);
    logic [7:0] cnt_reg;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= 8'h00;
            o_valid <= 1'b0;
            o_data <= 8'h00;
            o_ctrl <= 1'b0;
            o_inv <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            if (i_slow && cnt_reg[3:0] == 4'h3) begin
                // Slower sender: idle line shows the inverse, not a stale value
                o_valid <= 1'b0;
                o_data <= ~o_data;
            end else if (cnt_reg[4:1] == 4'h8) begin
                o_valid <= 1'b1;
                o_data <= 8'h1C;
                o_ctrl <= i_cc_ctrl;
            end else if (i_bond && cnt_reg == 8'h88) begin
                o_valid <= 1'b1;
                o_data <= 8'h7C;
                o_ctrl <= 1'b1;
            end else begin
                // Odd filler never equals a sequence pattern
                o_valid <= 1'b1;
                o_data <= {cnt_reg[6:0], 1'b1};
                o_ctrl <= 1'b0;
            end
        end
    end
endmodule : rbm_remote_tx

/* File: tb/rbm_top_checker.sv */
// Port-level assertions for the lane bonding and rate match block
`timescale 1ns/1ns
module rbm_top_checker (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    // Stream and bonding
    input wire logic O_OUT_VALID,
    input wire logic O_BOND_GO,
    input wire logic O_BOND_DONE,
    // Register bus
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESET_N);
    // Once running the output valid never drops
    a_out_steady: assert property (O_OUT_VALID |=> O_OUT_VALID)
        else $error("output stream stalled");
    a_bond_sticky: assert property (O_BOND_DONE |=> O_BOND_DONE)
        else $error("bond done dropped");
    a_bond_pulse: assert property (O_BOND_GO |=> !O_BOND_GO)
        else $error("bond start not a pulse");
    a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response not held");
    a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data not held");
    a_ar_taken: assert property (S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID |=> S_AXI_ARREADY)
        else $error("read address not taken");
    a_rvalid_next: assert property (S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    a_bvalid_after: assert property (S_AXI_AWREADY && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
        else $error("write answer late");
    a_awready_pulse: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("address ready not a pulse");
endmodule : rbm_top_checker
bind rbm_top rbm_top_checker u_chk (.I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N), .O_OUT_VALID(O_OUT_VALID),
    .O_BOND_GO(O_BOND_GO), .O_BOND_DONE(O_BOND_DONE), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

/* File: tb/rbm_top_tb.sv */
// Self-checking bench for the lane bonding and rate match block
`timescale 1ns/1ns
module rbm_top_tb;
    logic sys_clk = 1'b0, reset_n = 1'b0, slow = 1'b0, cc_ctrl = 1'b1, bond = 1'b0, bond_master = 1'b0;
    logic rx_valid, rx_ctrl, rx_inv, out_valid, out_ctrl, bond_go, bond_done;
    logic [7:0] rx_data, out_data, awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic bond_in = 1'b0, go_seen;
    logic [31:0] wdata = 32'h0, rdata, lfsr_reg = 32'hF201;
    logic [1:0] bresp, rresp;
    int err_total = 0, comparisons = 0;
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) go_seen <= 1'b0;
        else if (bond_go) go_seen <= 1'b1;
    end
    rbm_remote_tx u_tx (.i_clk(sys_clk), .i_rst_n(reset_n), .i_slow(slow), .i_cc_ctrl(cc_ctrl), .i_bond(bond),
        .o_valid(rx_valid), .o_data(rx_data), .o_ctrl(rx_ctrl), .o_inv(rx_inv));
    rbm_top DUT (.I_SYS_CLK(sys_clk), .I_RESET_N(reset_n), .I_RX_VALID(rx_valid), .I_RX_DATA(rx_data),
        .I_RX_CTRL(rx_ctrl), .I_RX_INV(rx_inv), .O_OUT_VALID(out_valid), .O_OUT_DATA(out_data),
        .O_OUT_CTRL(out_ctrl), .I_BOND_MASTER(bond_master), .I_BOND_GO(bond_in), .O_BOND_GO(bond_go),
        .O_BOND_DONE(bond_done), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Only the enable, two-sequence and length fields are stored
    function automatic logic [31:0] exp_ctrl(input logic [31:0] v);
        return v & 32'h0000_077F;
    endfunction : exp_ctrl
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check({30'h0, r}, {30'h0, rbm_pkg::RESP_OKAY}, "write response");
    endtask : wr
    task automatic do_reset();
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
    endtask : do_reset
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        print_verdict();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        axi_read(rbm_pkg::ADDR_CTRL, d, r);
        check(d, rbm_pkg::CTRL_RESET, "control reset");
        axi_read(rbm_pkg::ADDR_SKEW, d, r);
        check(d, {28'h0, rbm_pkg::SKEW_RESET}, "skew reset");
        axi_read(rbm_pkg::ADDR_SEQ_BASE, d, r);
        check(d, {21'h0, rbm_pkg::SYM_RESET}, "symbol reset");
        axi_read(8'h20, d, r);
        check({30'h0, r}, {30'h0, rbm_pkg::RESP_SLVERR}, "unmapped read");
        axi_write(8'h24, lfsr_reg, r);
        check({30'h0, r}, {30'h0, rbm_pkg::RESP_SLVERR}, "unmapped write");
        for (int i = 0; i < 4; i++) begin
            lfsr_reg = lfsr(lfsr_reg);
            wr(rbm_pkg::ADDR_CTRL, lfsr_reg);
            axi_read(rbm_pkg::ADDR_CTRL, d, r);
            check(d, exp_ctrl(lfsr_reg), "control readback");
        end
        $display("register test done");
        // Modes: first table, second table only, control flag mismatch
        for (int m = 0; m < 3; m++) begin
            slow <= 1'b1;
            cc_ctrl <= (m != 2);
            do_reset();
            for (int k = 8; k < 14; k++) wr(8'h40 + 8'(4 * k), (m == 1 && k < 10) ? 32'h1FF : 32'h11C);
            wr(rbm_pkg::ADDR_CTRL, 32'h0000_0204 | (m == 1 ? 32'h8 : 32'h0));
            repeat (200) @(posedge sys_clk);
            axi_read(rbm_pkg::ADDR_CNT, d, r);
            check({31'h0, d[15:0] != 16'h0}, {31'h0, m != 2}, "characters added");
            check({16'h0, d[31:16]}, 32'h0, "characters dropped");
            axi_read(rbm_pkg::ADDR_STAT, d, r);
            check({30'h0, d[1:0]}, 32'h0, "buffer flow error");
            check({31'h0, out_valid}, 32'h1, "stream running");
        end
        $display("rate match test done");
        // Modes: master first table, master second table, slave on broadcast
        for (int m = 0; m < 3; m++) begin
            slow <= 1'b0;
            bond <= 1'b1;
            bond_master <= (m != 2);
            do_reset();
            wr(8'h40, m == 1 ? 32'h1FF : 32'h17C);
            wr(8'h50, 32'h17C);
            wr(rbm_pkg::ADDR_CTRL, 32'h0000_0011 | (m == 1 ? 32'h2 : 32'h0));
            if (m == 2) begin
                repeat (20) @(posedge sys_clk);
                bond_in <= 1'b1;
                @(posedge sys_clk);
                bond_in <= 1'b0;
            end
            repeat (300) @(posedge sys_clk);
            check({31'h0, bond_done}, 32'h1, "bond done");
            check({31'h0, go_seen}, {31'h0, m != 2}, "bond start broadcast");
            axi_read(rbm_pkg::ADDR_STAT, d, r);
            check({31'h0, d[3]}, 32'h1, "bond status");
        end
        $display("bonding test done");
        print_verdict();
    end
endmodule : rbm_top_tb

/* File: verilog/rbm_seq_match.sv */
// One sequence matcher over a sliding window of received symbols
`timescale 1ns/1ns
module rbm_seq_match #(
    parameter int SEQ_MAX = 4
) (
    // Window, oldest symbol first at index 0
    input wire logic [SEQ_MAX*8-1:0] i_win_data,
    input wire logic [SEQ_MAX-1:0] i_win_ctrl,
    input wire logic [SEQ_MAX-1:0] i_win_inv,
    // Configured table
    input wire logic [SEQ_MAX*11-1:0] i_tbl,
    input wire logic [2:0] i_len,
    input wire logic i_ctrl_chk,
    // Result
    output logic o_hit
);
    initial begin
        if (SEQ_MAX < 1 || SEQ_MAX > 7) $error("SEQ_MAX out of range");
    end

    // Window holds the newest SEQ_MAX symbols; match the last len of them
    always_comb begin
        logic ok;
        logic [10:0] ent;
        int pos;
        ent = '0;
        pos = 0;
        ok = (i_len != 3'h0);
        for (int k = 0; k < SEQ_MAX; k++) begin
            pos = SEQ_MAX - 32'(i_len) + k;
            ent = i_tbl[k*11 +: 11];
            if (k < 32'(i_len) && !ent[rbm_pkg::SYM_ANY_BIT]) begin
                if (i_win_data[pos*8 +: 8] != ent[7:0]) ok = 1'b0;
                if (i_ctrl_chk && ent[rbm_pkg::SYM_CTRL_BIT] != i_win_ctrl[pos]) ok = 1'b0;
                if (i_win_inv[pos] && !ent[rbm_pkg::SYM_INV_BIT]) ok = 1'b0;
            end
        end
        o_hit = ok;
    end
endmodule : rbm_seq_match

/* File: verilog/rbm_top.sv */
// Receive elastic buffer with lane bonding and rate matching
`timescale 1ns/1ns
module rbm_top #(
    parameter int SEQ_MAX = rbm_pkg::SEQ_MAX,
    parameter int DEPTH = rbm_pkg::DEPTH
) (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    // Received symbol stream
    input wire logic I_RX_VALID,
    input wire logic [7:0] I_RX_DATA,
    input wire logic I_RX_CTRL,
    input wire logic I_RX_INV,
    // Output stream, one symbol per cycle once running
    output logic O_OUT_VALID,
    output logic [7:0] O_OUT_DATA,
    output logic O_OUT_CTRL,
    // Lane bonding: master aligns, slaves follow
    input wire logic I_BOND_MASTER,
    input wire logic I_BOND_GO,
    output logic O_BOND_GO,
    output logic O_BOND_DONE,
    // AXI4-Lite slave
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    localparam int PW = $clog2(DEPTH);
    initial begin
        if (DEPTH != 32 || SEQ_MAX != 4) $error("unsupported DEPTH or SEQ_MAX");
    end

    function automatic logic [PW-1:0] occ(input logic [PW-1:0] w, input logic [PW-1:0] r);
        occ = PW'(w - r);
    endfunction : occ

    // Registers
    logic [31:0] ctrl_reg;
    logic [3:0] skew_reg;
    logic [10:0] tbl_reg [4*SEQ_MAX];
    logic [15:0] add_cnt_reg, drop_cnt_reg;
    logic sticky_under_reg, sticky_over_reg;

    // Buffer
    logic [9:0] mem [DEPTH];
    logic [PW-1:0] wp_reg, rp_reg;
    logic run_reg;
    logic [SEQ_MAX*8-1:0] win_d_reg;
    logic [SEQ_MAX-1:0] win_k_reg, win_i_reg;
    logic [PW-1:0] mark_reg [2];
    logic [SEQ_MAX*11-1:0] tbl_flat [4];
    logic [3:0] hit;
    logic [2:0] blen, clen;

    assign blen = ctrl_reg[rbm_pkg::CTRL_BLEN_LSB +: 3];
    assign clen = ctrl_reg[rbm_pkg::CTRL_CLEN_LSB +: 3];

    always_comb begin
        for (int t = 0; t < 4; t++) begin
            for (int k = 0; k < SEQ_MAX; k++) tbl_flat[t][k*11 +: 11] = tbl_reg[t*SEQ_MAX + k];
        end
    end

    for (genvar t = 0; t < 4; t++) begin : g_match
        rbm_seq_match #(.SEQ_MAX(SEQ_MAX)) u_match (
            .i_win_data(win_d_reg),
            .i_win_ctrl(win_k_reg),
            .i_win_inv(win_i_reg),
            .i_tbl(tbl_flat[t]),
            .i_len((t < 2) ? blen : clen),
            .i_ctrl_chk(1'b1),
            .o_hit(hit[t])
        );
    end

    logic bond_hit, corr_hit;
    assign bond_hit = ctrl_reg[rbm_pkg::CTRL_BOND_EN] && (hit[rbm_pkg::TBL_BOND1] ||
        (ctrl_reg[rbm_pkg::CTRL_BOND_TWO] && hit[rbm_pkg::TBL_BOND2]));
    assign corr_hit = ctrl_reg[rbm_pkg::CTRL_CORR_EN] && (hit[rbm_pkg::TBL_CORR1] ||
        (ctrl_reg[rbm_pkg::CTRL_CORR_TWO] && hit[rbm_pkg::TBL_CORR2]));

    // Write side: window shift and buffer store; drops still store, then rewind the write pointer
    logic [PW-1:0] fill;
    logic do_drop;
    assign fill = occ(wp_reg, rp_reg);
    // Drop a matched correction sequence of any length when fill is above OCC_MID + OCC_SLACK; it is
    // dropped whole only if no symbol arrives that cycle, else its first symbol stays and the arriving one is lost
    assign do_drop = corr_hit && run_reg && (fill > rbm_pkg::OCC_MID + rbm_pkg::OCC_SLACK);

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            win_d_reg <= '0;
            win_k_reg <= '0;
            win_i_reg <= '0;
        end else if (I_RX_VALID) begin
            win_d_reg <= {I_RX_DATA, win_d_reg[SEQ_MAX*8-1:8]};
            win_k_reg <= {I_RX_CTRL, win_k_reg[SEQ_MAX-1:1]};
            win_i_reg <= {I_RX_INV, win_i_reg[SEQ_MAX-1:1]};
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RX_VALID) mem[wp_reg] <= {I_RX_INV, I_RX_CTRL, I_RX_DATA};
    end

    // Write pointer: a drop rewinds by the sequence length, less one when a symbol arrives in the same cycle
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            wp_reg <= '0;
        end else if (do_drop) begin
            wp_reg <= PW'(wp_reg - PW'(clen) + PW'(I_RX_VALID));
        end else if (I_RX_VALID) begin
            wp_reg <= PW'(wp_reg + 1'b1);
        end
    end

    // Bonding marks: where the last bonding sequence ended in the buffer
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            mark_reg[0] <= '0;
            mark_reg[1] <= '0;
        end else if (bond_hit) begin
            mark_reg[0] <= wp_reg;
            mark_reg[1] <= mark_reg[0];
        end
    end

    // Read side: starts at midpoint; insert repeats a whole sequence
    logic do_add;
    logic bond_now;
    assign do_add = corr_hit && run_reg && !do_drop && (fill < rbm_pkg::OCC_MID - rbm_pkg::OCC_SLACK);
    // Master aligns on its own hit; slaves align on the master's broadcast, relying on the
    // remote spacing keeping every lane's copy within the skew window
    assign bond_now = ctrl_reg[rbm_pkg::CTRL_BOND_EN] && (I_BOND_MASTER ? bond_hit : I_BOND_GO);

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rp_reg <= '0;
            run_reg <= 1'b0;
        end else if (!run_reg) begin
            run_reg <= (fill >= rbm_pkg::OCC_MID);
        end else if (bond_now) begin
            rp_reg <= PW'(mark_reg[0] - PW'(skew_reg));
        end else if (do_add) begin
            rp_reg <= PW'(rp_reg + 1'b1 - PW'(clen));
        end else begin
            rp_reg <= PW'(rp_reg + 1'b1);
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_OUT_VALID <= 1'b0;
            O_OUT_DATA <= '0;
            O_OUT_CTRL <= 1'b0;
            O_BOND_GO <= 1'b0;
            O_BOND_DONE <= 1'b0;
        end else begin
            O_OUT_VALID <= run_reg;
            O_OUT_DATA <= run_reg ? mem[rp_reg][7:0] : 8'h00;
            O_OUT_CTRL <= run_reg && mem[rp_reg][8];
            O_BOND_GO <= I_BOND_MASTER && bond_hit;
            O_BOND_DONE <= O_BOND_DONE || (run_reg && bond_now);
        end
    end

    // Counters and sticky status; sticky set wins over clear, counter clear wins over count
    logic stat_clr;
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            add_cnt_reg <= '0;
            drop_cnt_reg <= '0;
            sticky_under_reg <= 1'b0;
            sticky_over_reg <= 1'b0;
        end else begin
            add_cnt_reg <= stat_clr ? '0 : 16'(add_cnt_reg + 16'(do_add));
            drop_cnt_reg <= stat_clr ? '0 : 16'(drop_cnt_reg + 16'(do_drop));
            sticky_under_reg <= (run_reg && fill == '0) || (sticky_under_reg && !stat_clr);
            sticky_over_reg <= (run_reg && fill == PW'(DEPTH - 1)) || (sticky_over_reg && !stat_clr);
        end
    end

    // AXI4-Lite write channel
    logic aw_ok, w_ok;
    logic [7:0] aw_reg;
    logic [31:0] wd_reg;
    logic [3:0] ws_reg;
    logic wr_fire;
    assign wr_fire = aw_ok && w_ok && !S_AXI_BVALID;
    assign stat_clr = wr_fire && aw_reg == rbm_pkg::ADDR_STAT;

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            aw_ok <= 1'b0;
            w_ok <= 1'b0;
            aw_reg <= '0;
            wd_reg <= '0;
            ws_reg <= '0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= rbm_pkg::RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= !aw_ok && !S_AXI_AWREADY && S_AXI_AWVALID;
            S_AXI_WREADY <= !w_ok && !S_AXI_WREADY && S_AXI_WVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_ok <= 1'b1;
                aw_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_ok <= 1'b1;
                wd_reg <= S_AXI_WDATA;
                // Strobes travel with the data beat, not with the later commit
                ws_reg <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_ok <= 1'b0;
                w_ok <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (aw_reg == rbm_pkg::ADDR_CTRL || aw_reg == rbm_pkg::ADDR_STAT ||
                    aw_reg == rbm_pkg::ADDR_SKEW || (aw_reg >= rbm_pkg::ADDR_SEQ_BASE &&
                    aw_reg < rbm_pkg::ADDR_SEQ_BASE + 8'(16 * SEQ_MAX))) ?
                    rbm_pkg::RESP_OKAY : rbm_pkg::RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Register writes; byte strobes honoured on the low lanes in use
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ctrl_reg <= rbm_pkg::CTRL_RESET;
            skew_reg <= rbm_pkg::SKEW_RESET;
            for (int i = 0; i < 4 * SEQ_MAX; i++) tbl_reg[i] <= rbm_pkg::SYM_RESET;
        end else if (wr_fire) begin
            if (aw_reg == rbm_pkg::ADDR_CTRL) begin
                if (ws_reg[0]) ctrl_reg[7:0] <= wd_reg[7:0] & rbm_pkg::CTRL_MASK[7:0];
                if (ws_reg[1]) ctrl_reg[15:8] <= wd_reg[15:8] & rbm_pkg::CTRL_MASK[15:8];
            end
            if (aw_reg == rbm_pkg::ADDR_SKEW && ws_reg[0]) skew_reg <= wd_reg[3:0];
            if (aw_reg >= rbm_pkg::ADDR_SEQ_BASE && aw_reg < rbm_pkg::ADDR_SEQ_BASE + 8'(16 * SEQ_MAX)) begin
                if (ws_reg[0]) tbl_reg[aw_reg[5:2]][7:0] <= wd_reg[7:0];
                if (ws_reg[1]) tbl_reg[aw_reg[5:2]][10:8] <= wd_reg[10:8];
            end
        end
    end

    // AXI4-Lite read channel, one cycle from address to data
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= rbm_pkg::RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= rbm_pkg::RESP_OKAY;
                S_AXI_RDATA <= '0;
                if (S_AXI_ARADDR == rbm_pkg::ADDR_CTRL) S_AXI_RDATA <= {16'h0000, ctrl_reg[15:0]};
                else if (S_AXI_ARADDR == rbm_pkg::ADDR_STAT)
                    S_AXI_RDATA <= {16'h0000, 3'h0, PW'(fill), 4'h0, O_BOND_DONE, run_reg,
                        sticky_over_reg, sticky_under_reg};
                else if (S_AXI_ARADDR == rbm_pkg::ADDR_SKEW) S_AXI_RDATA <= {28'h0000000, skew_reg};
                else if (S_AXI_ARADDR == rbm_pkg::ADDR_CNT) S_AXI_RDATA <= {drop_cnt_reg, add_cnt_reg};
                else if (S_AXI_ARADDR >= rbm_pkg::ADDR_SEQ_BASE &&
                    S_AXI_ARADDR < rbm_pkg::ADDR_SEQ_BASE + 8'(16 * SEQ_MAX))
                    S_AXI_RDATA <= {21'h000000, tbl_reg[S_AXI_ARADDR[5:2]]};
                else S_AXI_RRESP <= rbm_pkg::RESP_SLVERR;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule : rbm_top
